// file: shared/dmab_pkg.sv
package dmab_pkg;
  // Register byte offsets on the APB window
  localparam logic [7:0] OFS_SRC = 8'h00;
  localparam logic [7:0] OFS_DST = 8'h04;
  localparam logic [7:0] OFS_TCA = 8'h08;
  localparam logic [7:0] OFS_BLK = 8'h0c;
  localparam logic [7:0] OFS_CTL = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;

  // Control register field positions
  localparam int CTL_CHAN_EN = 0;
  localparam int CTL_END_IE = 1;
  localparam int CTL_MASTER_EN = 2;
  localparam int CTL_BURST = 3;
  localparam int CTL_WORD = 4;
  localparam int CTL_AREA_SRC = 5;
  localparam int CTL_SRC_STEP = 6;
  localparam int CTL_DST_STEP = 8;
  localparam int CTL_ACT_SRC = 10;
  localparam int CTL_MODE = 14;

  // Status register field positions
  localparam int STAT_END = 0;
  localparam int STAT_BUSY = 1;
  localparam int STAT_IN_BLOCK = 2;
  localparam int STAT_PENDING = 3;

  // Values after reset
  localparam logic [15:0] CTL_RST = 16'h0000;
  localparam logic [23:0] ADDR_RST = 24'h000000;
  localparam logic [15:0] CNT_RST = 16'h0000;

  // States between pin activation and the first bus request
  localparam logic [2:0] START_WAIT_CYC = 3'h4;

  typedef enum logic [1:0] {
    MODE_SHORT_A, MODE_SHORT_B, MODE_NORMAL, MODE_BLOCK
  } dmab_mode_type;

  typedef enum logic [3:0] {
    SRC_TMR0, SRC_TMR1, SRC_TMR2, SRC_TMR3, SRC_SER_TX, SRC_SER_RX,
    SRC_EXT_EDGE, SRC_EXT_LEVEL, SRC_AUTO
  } dmab_src_type;

  typedef enum logic [1:0] {STEP_FIX, STEP_INC, STEP_DEC} dmab_step_type;

  typedef enum logic [2:0] {
    ST_IDLE, ST_WAIT, ST_BREQ, ST_READ, ST_WRITE
  } dmab_state_type;
endpackage : dmab_pkg

// file: rtl/dmab_addr_step.sv
`timescale 1ns/1ps
`default_nettype none
module dmab_addr_step (
  input wire logic [23:0] addr,
  input wire logic [1:0] step,
  input wire logic word,
  output logic [23:0] next
);
  // Stride follows the unit size
  logic [23:0] delta;
  assign delta = word ? 24'h000002 : 24'h000001;

  // Unused step code holds the address like fixed
  always_comb begin
    case (dmab_pkg::dmab_step_type'(step))
      dmab_pkg::STEP_INC: next = addr + delta;
      dmab_pkg::STEP_DEC: next = addr - delta;
      default: next = addr;
    endcase
  end
endmodule : dmab_addr_step
`default_nettype wire

// file: rtl/dmab_req_sync.sv
`timescale 1ns/1ps
`default_nettype none
module dmab_req_sync (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic pin_n,
  output logic low,
  output logic fall
);
  // Two stages, then one more for the edge history
  logic [1:0] sync_q;
  logic prev_q;

  // Pin idles high, so the chain resets high
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_q <= 2'b11;
      prev_q <= 1'b1;
    end else begin
      sync_q <= {sync_q[0], pin_n};
      prev_q <= sync_q[1];
    end
  end

  assign low = ~sync_q[1];
  assign fall = prev_q & ~sync_q[1];
endmodule : dmab_req_sync
`default_nettype wire

// file: rtl/dmab_core.sv
// Function
// R1: Block mode merges channels, repeats N blocks
// R2: 24-bit source, destination, each steps independently
// R3: Each accepted request bursts one whole block
// R4: Size counter zero reloads, restores, decrements blocks
// R5: Block-area address restored after every block
// R6: Area select zero means destination area
// R7: More blocks left: wait for next request
// R8: Last block clears enable, optional CPU interrupt
// R9: Software loads size M and count N
// R10: Block mode accepts only timers, pin edges
// R11: Sources gated by mode and channel type
// R12: Selected interrupt withheld from CPU while enabled
// R13: Activation clears the interrupt request flag
// R14: Shared interrupt stays pending in lower channels
// R15: Pin source forces request in, end out
// R16: Each falling edge moves one unit
// R17: Low level keeps transferring, bus released per unit
// R18: Low request latched until one unit moves
// R19: End pin low in final write cycle
// R20: Block mode edge only, end per block
// R21: Auto-request starts at enable, runs to end
// R22: Cycle steal releases per unit; burst holds
// R23: Enable cleared halts after current unit
// R24: Four states before start, pin unsampled
// R25: Block-area address captured at block start
//
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module dmab_core (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic bus_req,
  input wire logic bus_gnt,
  input wire logic hp_bus_req,
  output logic [23:0] bus_addr,
  output logic bus_rd,
  output logic bus_wr,
  output logic bus_word,
  output logic [15:0] bus_wdata,
  input wire logic [15:0] bus_rdata,
  input wire logic bus_ack,
  input wire logic [3:0] timer_match_irq,
  output logic [3:0] timer_irq_to_cpu,
  output logic [3:0] timer_flag_clr,
  input wire logic transfer_request_pin_n,
  output logic request_pin_input,
  output logic transfer_end_pin_n,
  output logic transfer_end_pin_oe,
  output logic end_irq
);
  // Reset release chain; everything below uses rst_n
  logic [1:0] rst_q;
  logic rst_n;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) rst_q <= 2'b00;
    else rst_q <= {rst_q[0], 1'b1};
  end
  assign rst_n = rst_q[1];

  // Software visible registers
  logic [15:0] ctl_q;
  logic [23:0] src_q, src_d, src_nx;
  logic [23:0] dst_q, dst_d, dst_nx;
  logic [23:0] area_q; // Block-area start copy
  logic [15:0] tca_q, tca_d; // Block mode: high byte counts, low byte reloads; other modes count all 16 bits
  logic [15:0] blk_q, blk_d;
  dmab_pkg::dmab_state_type state_q, state_d;
  logic [2:0] wait_q;
  logic in_blk_q, samp_en_q, edge_q, lvl_q, tmr_pend_q;

  // Control decode
  dmab_pkg::dmab_mode_type mode;
  dmab_pkg::dmab_src_type act_src;
  logic en, blk_mode, run_mode, area_src, src_ok;
  assign mode = dmab_pkg::dmab_mode_type'(ctl_q[dmab_pkg::CTL_MODE +: 2]);
  assign act_src = dmab_pkg::dmab_src_type'(ctl_q[dmab_pkg::CTL_ACT_SRC +: 4]);
  assign en = ctl_q[dmab_pkg::CTL_CHAN_EN] & ctl_q[dmab_pkg::CTL_MASTER_EN];
  assign blk_mode = (mode == dmab_pkg::MODE_BLOCK);
  assign run_mode = blk_mode | (mode == dmab_pkg::MODE_NORMAL); // R1
  assign area_src = ctl_q[dmab_pkg::CTL_AREA_SRC];

  // Source permission per mode and channel type
  function automatic logic allowed(input dmab_pkg::dmab_mode_type m,
                                   input dmab_pkg::dmab_src_type s);
    logic tmr, ser, ext_e, ext_l;
    tmr = (s == dmab_pkg::SRC_TMR0) | (s == dmab_pkg::SRC_TMR1) |
          (s == dmab_pkg::SRC_TMR2) | (s == dmab_pkg::SRC_TMR3);
    ser = (s == dmab_pkg::SRC_SER_TX) | (s == dmab_pkg::SRC_SER_RX);
    ext_e = (s == dmab_pkg::SRC_EXT_EDGE);
    ext_l = (s == dmab_pkg::SRC_EXT_LEVEL);
    unique case (m)
      dmab_pkg::MODE_SHORT_A: allowed = tmr | ser; // R11
      dmab_pkg::MODE_SHORT_B: allowed = tmr | ser | ext_e | ext_l; // R11
      dmab_pkg::MODE_NORMAL: // R11
        allowed = ext_e | ext_l | (s == dmab_pkg::SRC_AUTO); // R21
      dmab_pkg::MODE_BLOCK: allowed = tmr | ext_e; // R10 R20
    endcase
  endfunction : allowed
  assign src_ok = allowed(mode, act_src);

  // APB decode; a transfer completes when pready is seen
  logic apb_acc, wr_hit, wr_ctl, wr_src, wr_dst, wr_tca, wr_blk, hit;
  logic [31:0] rdata_d;
  assign apb_acc = psel & penable & pready;
  assign wr_hit = apb_acc & pwrite;
  assign wr_ctl = wr_hit & (paddr == dmab_pkg::OFS_CTL);
  assign wr_src = wr_hit & (paddr == dmab_pkg::OFS_SRC);
  assign wr_dst = wr_hit & (paddr == dmab_pkg::OFS_DST);
  assign wr_tca = wr_hit & (paddr == dmab_pkg::OFS_TCA);
  assign wr_blk = wr_hit & (paddr == dmab_pkg::OFS_BLK);

  // Read mux; unmapped addresses read zero with an error
  always_comb begin
    rdata_d = 32'h00000000;
    hit = 1'b1;
    case (paddr)
      dmab_pkg::OFS_SRC: rdata_d = {8'h00, src_q};
      dmab_pkg::OFS_DST: rdata_d = {8'h00, dst_q};
      dmab_pkg::OFS_TCA: rdata_d = {16'h0000, tca_q};
      dmab_pkg::OFS_BLK: rdata_d = {16'h0000, blk_q};
      dmab_pkg::OFS_CTL: rdata_d = {16'h0000, ctl_q};
      dmab_pkg::OFS_STAT: begin
        rdata_d[dmab_pkg::STAT_END] = end_irq;
        rdata_d[dmab_pkg::STAT_BUSY] = (state_q != dmab_pkg::ST_IDLE);
        rdata_d[dmab_pkg::STAT_IN_BLOCK] = in_blk_q;
        rdata_d[dmab_pkg::STAT_PENDING] = edge_q | lvl_q | tmr_pend_q;
      end
      default: hit = 1'b0;
    endcase
  end

  // One wait state on every access, answer from flops
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
      prdata <= (psel & penable & ~pready & ~pwrite) ? rdata_d : 32'h0;
      pslverr <= psel & penable & ~pready & ~hit;
    end
  end

  // Pin request synchroniser and edge detector
  logic req_low, req_fall;
  dmab_req_sync u_req_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pin_n(transfer_request_pin_n),
    .low(req_low),
    .fall(req_fall)
  );

  // Address steppers for both pointers
  dmab_addr_step u_src_step (
    .addr(src_q),
    .step(ctl_q[dmab_pkg::CTL_SRC_STEP +: 2]),
    .word(ctl_q[dmab_pkg::CTL_WORD]),
    .next(src_nx)
  );
  dmab_addr_step u_dst_step (
    .addr(dst_q),
    .step(ctl_q[dmab_pkg::CTL_DST_STEP +: 2]),
    .word(ctl_q[dmab_pkg::CTL_WORD]),
    .next(dst_nx)
  );

  // Request gathering
  logic irq_sel, raw_req, go, take, unit_done;
  logic last_in_blk, last_blk, last_unit, fin, keep_bus;
  assign irq_sel = timer_match_irq[act_src[1:0]];
  always_comb begin
    unique case (act_src)
      dmab_pkg::SRC_TMR0, dmab_pkg::SRC_TMR1,
      dmab_pkg::SRC_TMR2, dmab_pkg::SRC_TMR3:
        raw_req = irq_sel | tmr_pend_q; // R14
      dmab_pkg::SRC_EXT_EDGE: raw_req = edge_q; // R16 R20
      dmab_pkg::SRC_EXT_LEVEL: raw_req = lvl_q; // R17
      dmab_pkg::SRC_AUTO: raw_req = 1'b1; // R21
      default: raw_req = 1'b0; // Serial and unused codes
    endcase
  end
  // An interrupted block resumes without a fresh request
  assign go = (state_q == dmab_pkg::ST_IDLE) & en & run_mode &
              (in_blk_q | (src_ok & raw_req)); // R7
  assign take = go & ~in_blk_q;
  assign unit_done = (state_q == dmab_pkg::ST_WRITE) & bus_ack;
  assign last_in_blk = (tca_q[15:8] == 8'h01);
  assign last_blk = (blk_q == 16'h0001);
  assign last_unit = blk_mode ? last_in_blk : (tca_q == 16'h0001);
  assign fin = blk_mode ? (last_in_blk & last_blk) : last_unit;
  // Bus kept only within a block or an auto burst
  assign keep_bus = en & ~hp_bus_req & ~last_unit &
    (blk_mode | (ctl_q[dmab_pkg::CTL_BURST] &
                 (act_src == dmab_pkg::SRC_AUTO))); // R3 R22 R23

  // Next state and datapath
  always_comb begin
    state_d = state_q;
    src_d = src_q;
    dst_d = dst_q;
    tca_d = tca_q;
    blk_d = blk_q;
    unique case (state_q)
      dmab_pkg::ST_IDLE: if (go) state_d = dmab_pkg::ST_WAIT;
      dmab_pkg::ST_WAIT: begin
        if (wait_q == dmab_pkg::START_WAIT_CYC - 3'h1) begin // R24
          state_d = dmab_pkg::ST_BREQ;
        end
      end
      dmab_pkg::ST_BREQ: if (bus_gnt) state_d = dmab_pkg::ST_READ;
      dmab_pkg::ST_READ: if (bus_ack) state_d = dmab_pkg::ST_WRITE;
      dmab_pkg::ST_WRITE: begin
        if (bus_ack) begin
          src_d = src_nx; // R2
          dst_d = dst_nx; // R2
          if (blk_mode && last_in_blk) begin
            tca_d = {tca_q[7:0], tca_q[7:0]}; // R4
            blk_d = blk_q - 16'h0001; // R4
            if (area_src) src_d = area_q; // R5 R6
            else dst_d = area_q; // R5 R6
          end else if (blk_mode) begin
            tca_d = {tca_q[15:8] - 8'h01, tca_q[7:0]}; // R3
          end else begin
            tca_d = tca_q - 16'h0001;
          end
          state_d = keep_bus ? dmab_pkg::ST_READ : dmab_pkg::ST_IDLE;
        end
      end
    endcase
  end

  // Sequencer state and start delay
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= dmab_pkg::ST_IDLE;
      wait_q <= 3'h0;
    end else begin
      state_q <= state_d;
      wait_q <= (state_q == dmab_pkg::ST_WAIT) ? wait_q + 3'h1 : 3'h0;
    end
  end

  // Address and count registers; software writes win
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      src_q <= dmab_pkg::ADDR_RST;
      dst_q <= dmab_pkg::ADDR_RST;
      tca_q <= dmab_pkg::CNT_RST;
      blk_q <= dmab_pkg::CNT_RST;
    end else begin
      src_q <= wr_src ? pwdata[23:0] : src_d;
      dst_q <= wr_dst ? pwdata[23:0] : dst_d;
      tca_q <= wr_tca ? pwdata[15:0] : tca_d;
      blk_q <= wr_blk ? pwdata[15:0] : blk_d;
    end
  end

  // Block tracking: area copy taken as a block begins
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      area_q <= dmab_pkg::ADDR_RST;
      in_blk_q <= 1'b0;
    end else begin
      if (take && blk_mode) begin
        area_q <= area_src ? src_q : dst_q; // R25
        in_blk_q <= 1'b1;
      end else if (unit_done && (!blk_mode || last_in_blk)) begin
        in_blk_q <= 1'b0; // R7
      end
    end
  end

  // Control register; hardware drops the enable at the end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) ctl_q <= dmab_pkg::CTL_RST;
    else if (wr_ctl) ctl_q <= pwdata[15:0];
    else if (unit_done && fin) ctl_q[dmab_pkg::CTL_CHAN_EN] <= 1'b0; // R8
  end

  // End flag: set wins over a one-to-clear write
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) end_irq <= 1'b0;
    else if (unit_done && fin && ctl_q[dmab_pkg::CTL_END_IE]) end_irq <= 1'b1; // R8
    else if (wr_hit && paddr == dmab_pkg::OFS_STAT && pwdata[dmab_pkg::STAT_END])
      end_irq <= 1'b0;
  end

  // Request latches; pin ignored from activation to end of read
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      samp_en_q <= 1'b1;
      edge_q <= 1'b0;
      lvl_q <= 1'b0;
      tmr_pend_q <= 1'b0;
    end else begin
      if (state_q == dmab_pkg::ST_READ && bus_ack) samp_en_q <= 1'b1; // R24
      else if (take) samp_en_q <= 1'b0; // R24
      if (req_fall && samp_en_q) edge_q <= 1'b1; // R16
      else if (take) edge_q <= 1'b0;
      if (req_low && samp_en_q) lvl_q <= 1'b1; // R18
      else if (unit_done) lvl_q <= 1'b0; // R17
      // Only a timer source may leave a stale pending behind
      tmr_pend_q <= (tmr_pend_q | (irq_sel & (act_src[3:2] == 2'b00) &
        (state_q == dmab_pkg::ST_IDLE))) & ~take; // R14
    end
  end

  // Bus master outputs follow the next state
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_req <= 1'b0;
      bus_rd <= 1'b0;
      bus_wr <= 1'b0;
      bus_addr <= dmab_pkg::ADDR_RST;
      bus_word <= 1'b0;
      bus_wdata <= 16'h0000;
      transfer_end_pin_n <= 1'b1;
    end else begin
      bus_req <= (state_d == dmab_pkg::ST_BREQ) |
                 (state_d == dmab_pkg::ST_READ) |
                 (state_d == dmab_pkg::ST_WRITE); // R22
      bus_rd <= (state_d == dmab_pkg::ST_READ);
      bus_wr <= (state_d == dmab_pkg::ST_WRITE);
      bus_addr <= (state_d == dmab_pkg::ST_WRITE) ? dst_d : src_d;
      bus_word <= ctl_q[dmab_pkg::CTL_WORD];
      if (state_q == dmab_pkg::ST_READ && bus_ack) bus_wdata <= bus_rdata;
      transfer_end_pin_n <=
        ~((state_d == dmab_pkg::ST_WRITE) & last_unit); // R19 R20
    end
  end

  // Pin ownership overrides port direction
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      request_pin_input <= 1'b0;
      transfer_end_pin_oe <= 1'b0;
    end else begin
      request_pin_input <= (act_src == dmab_pkg::SRC_EXT_EDGE) |
                           (act_src == dmab_pkg::SRC_EXT_LEVEL); // R15
      transfer_end_pin_oe <= (act_src == dmab_pkg::SRC_EXT_EDGE) |
                             (act_src == dmab_pkg::SRC_EXT_LEVEL); // R15
    end
  end

  // Per timer: withhold from CPU, clear flag on activation
  logic [3:0] tsel;
  genvar k;
  generate
    for (k = 0; k < 4; k++) begin : g_tmr
      assign tsel[k] = ctl_q[dmab_pkg::CTL_CHAN_EN] & run_mode & src_ok &
                       (act_src[1:0] == 2'(k)) & (act_src[3:2] == 2'b00);
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          timer_irq_to_cpu[k] <= 1'b0;
          timer_flag_clr[k] <= 1'b0;
        end else begin
          timer_irq_to_cpu[k] <= timer_match_irq[k] & ~tsel[k]; // R12
          timer_flag_clr[k] <= take & tsel[k]; // R13
        end
      end
    end
  endgenerate

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence unit_end_s;
    state_q == dmab_pkg::ST_WRITE && bus_ack;
  endsequence
  sequence blk_end_s;
    unit_end_s ##0 (blk_mode && last_in_blk);
  endsequence

  chan_off_end_a: // R8
    assert property (blk_end_s ##0 (last_blk && !wr_ctl)
                     |=> !ctl_q[dmab_pkg::CTL_CHAN_EN])
    else $error("enable not cleared after last block");
  size_reload_a: // R4
    assert property (blk_end_s ##0 !wr_tca
                     |=> tca_q[15:8] == $past(tca_q[7:0]))
    else $error("block size counter not reloaded");
  area_restore_a: // R5
    assert property (blk_end_s ##0 (!area_src && !wr_dst)
                     |=> dst_q == $past(area_q))
    else $error("destination block area not restored");
  start_delay_a: // R24
    assert property ($rose(state_q == dmab_pkg::ST_WAIT)
                     |-> (state_q == dmab_pkg::ST_WAIT)[*4]
                     ##1 state_q == dmab_pkg::ST_BREQ)
    else $error("start delay not four cycles");
  flag_clear_a: // R13
    assert property (|timer_flag_clr |-> state_q == dmab_pkg::ST_WAIT &&
                     $past(state_q == dmab_pkg::ST_IDLE))
    else $error("flag cleared outside activation");
  irq_block_a: // R12
    assert property (|tsel |=> (timer_irq_to_cpu & $past(tsel)) == 4'h0)
    else $error("selected interrupt reached CPU");
  end_pin_write_a: // R19
    assert property (!transfer_end_pin_n |-> bus_wr)
    else $error("end pin low outside write");
  steal_release_a: // R22
    assert property (unit_end_s ##0 (!blk_mode &&
                     !ctl_q[dmab_pkg::CTL_BURST])
                     |=> state_q == dmab_pkg::ST_IDLE)
    else $error("bus not released after stolen cycle");
  block_burst_a: // R3
    assert property (unit_end_s ##0 (blk_mode && !last_in_blk && en &&
                     !hp_bus_req) |=> state_q == dmab_pkg::ST_READ)
    else $error("block burst broken");
endmodule : dmab_core
`default_nettype wire

// file: sim/dmab_sys_bus.sv
`timescale 1ns/1ps
`default_nettype none
// System bus slave: grants on request, answers each read or write
module dmab_sys_bus (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic slow,
  input wire logic bus_req,
  output logic bus_gnt,
  input wire logic [23:0] bus_addr,
  input wire logic bus_rd,
  input wire logic bus_wr,
  output logic [15:0] bus_rdata,
  output logic bus_ack
);
  logic [1:0] wait_q; // Wait states spent on the current cycle

  // Grant follows request; ack after zero or three wait states
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_gnt <= 1'b0;
      bus_ack <= 1'b0;
      bus_rdata <= 16'h0000;
      wait_q <= 2'h0;
    end else begin
      bus_gnt <= bus_req;
      if ((bus_rd || bus_wr) && !bus_ack && wait_q >= (slow ? 2'h3 : 2'h0)) begin
        bus_ack <= 1'b1;
        wait_q <= 2'h0;
        // Read data tells the address it came from
        bus_rdata <= bus_rd ? {8'ha5, bus_addr[7:0]} : ~bus_rdata;
      end else begin
        bus_ack <= 1'b0;
        // Data lines are not held outside an ack
        bus_rdata <= ~bus_rdata;
        wait_q <= (bus_ack || !(bus_rd || bus_wr)) ? 2'h0 : wait_q + 2'h1;
      end
    end
  end
endmodule : dmab_sys_bus
`default_nettype wire

// file: sim/dmab_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dmab_core_tb;
  typedef struct {logic [7:0] a; logic [31:0] w, r; logic e;} dmab_row_type;
  logic core_clk, arst_n, psel, penable, pwrite, pready, pslverr, slow;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic er, bus_req, bus_gnt, hp, bus_rd, bus_wr, bus_word, bus_ack, pin;
  logic [23:0] bus_addr;
  logic [15:0] bus_wdata, bus_rdata;
  logic [3:0] tmr, tmr_cpu, tmr_clr;
  logic pin_in, end_n, end_oe, end_irq, req_d;
  logic [23:0] wa[$]; // Write addresses seen
  logic [15:0] wd[$]; // Write data seen
  int n_mismatch, checks_done, n_end, n_breq, n_clr, nb;
  dmab_pkg::dmab_src_type bad[3] = '{dmab_pkg::SRC_EXT_LEVEL,
    dmab_pkg::SRC_AUTO, dmab_pkg::SRC_SER_RX};
  dmab_row_type rows[5] = '{
    '{dmab_pkg::OFS_SRC, 32'hffab_cdef, 32'h00ab_cdef, 1'b0},
    '{dmab_pkg::OFS_DST, 32'h0012_3456, 32'h0012_3456, 1'b0},
    '{dmab_pkg::OFS_TCA, 32'hffff_0203, 32'h0000_0203, 1'b0},
    '{dmab_pkg::OFS_BLK, 32'h1234_5678, 32'h0000_5678, 1'b0},
    '{8'h18, 32'h0000_0001, 32'h0000_0000, 1'b1}};

  dmab_core i_dmab_core (.core_clk(core_clk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus_req(bus_req),
    .bus_gnt(bus_gnt), .hp_bus_req(hp), .bus_addr(bus_addr), .bus_rd(bus_rd),
    .bus_wr(bus_wr), .bus_word(bus_word), .bus_wdata(bus_wdata),
    .bus_rdata(bus_rdata), .bus_ack(bus_ack), .timer_match_irq(tmr),
    .timer_irq_to_cpu(tmr_cpu), .timer_flag_clr(tmr_clr),
    .transfer_request_pin_n(pin), .request_pin_input(pin_in),
    .transfer_end_pin_n(end_n), .transfer_end_pin_oe(end_oe),
    .end_irq(end_irq));
  dmab_sys_bus i_dmab_sys_bus (.core_clk(core_clk), .arst_n(arst_n),
    .slow(slow), .bus_req(bus_req), .bus_gnt(bus_gnt), .bus_addr(bus_addr),
    .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_rdata(bus_rdata),
    .bus_ack(bus_ack));

  // 125 MHz clock
  always #4 core_clk = ~core_clk;

  // Bus monitor; the timer drops its flag when told, the rival drops too
  always @(posedge core_clk) begin
    req_d <= bus_req;
    if (bus_req && !req_d) n_breq++;
    if (bus_wr && bus_ack) begin
      wa.push_back(bus_addr);
      wd.push_back(bus_wdata);
      if (!end_n) n_end++;
      hp <= 1'b0;
    end
    if (tmr_clr[2]) begin
      n_clr++;
      tmr[2] <= 1'b0;
    end
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One APB transfer; pready and data sampled at the rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    if (n >= 20) n_mismatch++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Block mode, both steps up, destination as block area
  function automatic logic [31:0] mk(input logic [3:0] s);
    mk = 32'h0000_4007 | (32'h1 << dmab_pkg::CTL_SRC_STEP);
    mk = mk | (32'h1 << dmab_pkg::CTL_DST_STEP) | (32'h3 << dmab_pkg::CTL_MODE);
    mk = mk | (32'(s) << dmab_pkg::CTL_ACT_SRC);
  endfunction : mk

  // One falling edge on the request pin
  task pin_edge;
    @(posedge core_clk);
    pin <= 1'b0;
    repeat (3) @(posedge core_clk);
    pin <= 1'b1;
  endtask : pin_edge

  // Bounded wait for a total number of writes, then settle
  task wait_wr(input int n);
    int k;
    k = 0;
    while (wa.size() < n && k < 400) begin
      @(negedge core_clk);
      k++;
    end
    chk(32'(wa.size()), 32'(n));
    repeat (4) @(posedge core_clk);
  endtask : wait_wr

  task test_done;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done

  // Watchdog well past the expected run
  initial begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    test_done;
  end

  initial begin
    core_clk = 0; arst_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0;
    pwdata = 0; hp = 0; tmr = 0; pin = 1; slow = 0; req_d = 0;
    repeat (4) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk(32'(end_n), 32'h1);
    chk(32'(bus_req), 32'h0);
    apb(1'b0, dmab_pkg::OFS_CTL, 32'h0);
    chk(rd, 32'(dmab_pkg::CTL_RST));
    // Register table: write, read back, unmapped refusal
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].w);
      apb(1'b0, rows[i].a, 32'h0);
      chk(rd, rows[i].r);
      chk(32'(er), 32'(rows[i].e));
    end
    // Two blocks of two bytes on pin edges
    apb(1'b1, dmab_pkg::OFS_SRC, 32'h100);
    apb(1'b1, dmab_pkg::OFS_DST, 32'h200);
    apb(1'b1, dmab_pkg::OFS_TCA, 32'h0202);
    apb(1'b1, dmab_pkg::OFS_BLK, 32'h2);
    apb(1'b1, dmab_pkg::OFS_CTL, mk(dmab_pkg::SRC_EXT_EDGE));
    pin_edge;
    wait_wr(2);
    chk(32'({pin_in, end_oe}), 32'h3);
    chk(32'(bus_word), 32'h0);
    chk(32'(n_end), 32'h1);
    apb(1'b0, dmab_pkg::OFS_SRC, 32'h0);
    chk(rd, 32'h102);
    apb(1'b0, dmab_pkg::OFS_DST, 32'h0);
    chk(rd, 32'h200);
    apb(1'b0, dmab_pkg::OFS_TCA, 32'h0);
    chk(rd, 32'h0202);
    apb(1'b0, dmab_pkg::OFS_BLK, 32'h0);
    chk(rd, 32'h1);
    // Second block slowed and interrupted by a rival master
    hp <= 1'b1;
    slow <= 1'b1;
    pin_edge;
    wait_wr(4);
    chk(32'(n_breq), 32'h3);
    chk(32'(n_end), 32'h2);
    chk(32'(end_irq), 32'h1);
    apb(1'b0, dmab_pkg::OFS_CTL, 32'h0);
    chk(rd, mk(dmab_pkg::SRC_EXT_EDGE) & 32'hfffe);
    apb(1'b0, dmab_pkg::OFS_BLK, 32'h0);
    chk(rd, 32'h0);
    foreach (wa[i]) begin
      chk(32'(wa[i]), 32'h200 + 32'(i % 2));
      chk(32'(wd[i]), 32'ha500 + 32'(i));
    end
    slow <= 1'b0;
    // Timer source: flag cleared, withheld from the CPU
    apb(1'b1, dmab_pkg::OFS_DST, 32'h400);
    apb(1'b1, dmab_pkg::OFS_TCA, 32'h0101);
    apb(1'b1, dmab_pkg::OFS_BLK, 32'h1);
    tmr <= 4'b0110;
    apb(1'b1, dmab_pkg::OFS_CTL, mk(dmab_pkg::SRC_TMR2));
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    chk(32'(tmr_cpu), 32'h2);
    wait_wr(5);
    chk(32'(n_clr), 32'h1);
    chk(32'(wa[4]), 32'h400);
    chk(32'({pin_in, end_oe}), 32'h0);
    // Normal mode auto-request, cycle steal: bus freed per unit
    nb = n_breq;
    apb(1'b1, dmab_pkg::OFS_TCA, 32'h2);
    apb(1'b1, dmab_pkg::OFS_CTL, 32'ha145);
    wait_wr(7);
    chk(32'(n_breq), 32'(nb + 2));
    chk(32'(n_end), 32'h4);
    chk(32'(wa[6]), 32'h401);
    apb(1'b0, dmab_pkg::OFS_CTL, 32'h0);
    chk(rd, 32'ha144);
    // Sources not allowed in block mode start nothing
    apb(1'b1, dmab_pkg::OFS_BLK, 32'h1);
    pin <= 1'b0;
    foreach (bad[i]) begin
      nb = n_breq;
      apb(1'b1, dmab_pkg::OFS_CTL, mk(bad[i]));
      repeat (20) @(posedge core_clk);
      chk(32'(n_breq), 32'(nb));
    end
    test_done;
  end
endmodule : dmab_core_tb
`default_nettype wire
